/* verilog/prescaled_interval_counter.sv */
// Purpose: 8-bit interval counter behind a 6-bit prescaler, register mapped
// Assumes: Processor core reaches the mode, count and prescale registers
// Notes:   Read data is registered one clock after the address
//
// Contract
// R1: One 8-bit interval counter fed by its own 6-bit prescaler.
// R2: Counting runs on its own once started, no software per tick.
// R3: Single-pass stops at end-of-count; continuous reloads and keeps going.
// R4: Initial values move in at once by load, or at next end-of-count; single-pass takes the counter's initial value only by load.
// R5: Initial-value and prescale writes are accepted while counting runs.
// R6: Timer clock is the system clock divided by four.
// R7: Divide-by-four, prescaler and counter form one synchronous chain.
// R8: Counter may be clocked from the external port 5 bit 2 input.
// R9: Port 5 bit 6 carries the toggle output or the internal clock.
// R10: Timer output flips its level at every end-of-count.
// R11: Prescale unit is an 8-bit register plus a 6-bit down-counter.
// R12: Counter, prescale and mode registers sit in the register file.
// R13: Load bit copies both initial values, restarts, then clears itself.
// R14: Prescale value 0 divides by 64, value 1 passes clock through.
// R15: Both at end-of-count raise an interrupt; single-pass rests at zero.
// R16: Software picks single-pass with prescale bit 0 clear, continuous set.
// R17: After reset counting is disabled and the output function deselected.
`timescale 1ns/1ps
`default_nettype none
module prescaled_interval_counter (
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_port5_bit2_pin,
  output logic            o_port5_bit6_pin,
  output logic            o_timer_out_active,
  output logic            o_counter_interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] pre_reg;
  logic [7:0] pre_next;
  logic [7:0] init_reg;
  logic [7:0] init_next;
  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic       done_reg;
  logic       done_next;
  logic       toggle_reg;
  logic       toggle_next;
  logic       clkout_reg;
  logic       clkout_next;
  logic       pin_reg;
  logic       pin_next;
  logic       active_reg;
  logic       active_next;
  logic       irq_reg;
  logic       irq_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       ext_meta_reg;
  logic       ext_sync_reg;
  logic       ext_prev_reg;

  logic       wr_mode;
  logic       wr_count;
  logic       wr_pre;
  logic       load_now;
  logic       enable;
  logic       continuous;
  logic       int_tick;
  logic       ext_edge;
  logic       pre_tick;
  logic       pre_end;
  logic       eoc;
  logic [5:0] pre_count;
  logic [7:0] cnt_count;
  logic [1:0] out_sel;

  ////////////////////////////////////////////////////////////////////////////
  // External count input, two flops before any use
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      ext_meta_reg <= 1'h0;
      ext_sync_reg <= 1'h0;
      ext_prev_reg <= 1'h0;
    end else begin
      ext_meta_reg <= i_port5_bit2_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode and chain control
  always_comb begin
    wr_mode    = i_reg_wr & (i_reg_addr == interval_timer_pkg::ADDR_MODE); // R12
    wr_count   = i_reg_wr & (i_reg_addr == interval_timer_pkg::ADDR_COUNT);
    wr_pre     = i_reg_wr & (i_reg_addr == interval_timer_pkg::ADDR_PRESCALE);
    load_now   = mode_reg[interval_timer_pkg::MODE_LOAD_BIT]; // R13
    enable     = mode_reg[interval_timer_pkg::MODE_ENABLE_BIT]; // R2
    continuous = pre_reg[interval_timer_pkg::PRE_CONT_BIT]; // R16
    out_sel    = mode_reg[interval_timer_pkg::MODE_OUT_HI:
                          interval_timer_pkg::MODE_OUT_LO];
    ext_edge   = ext_sync_reg & ~ext_prev_reg; // R8
    int_tick   = enable & ~load_now &
                 (div_reg == interval_timer_pkg::TIMER_DIV_LAST); // R6
    if (pre_reg[interval_timer_pkg::PRE_INTCLK_BIT]) begin
      pre_tick = int_tick; // R7
    end else begin
      pre_tick = enable & ~load_now & ext_edge; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and interval counter stages
  countdown_stage #(
    .W(6)
  ) u_prescale_divider (
    .i_sys_clk(i_sys_clk),
    .i_nrst   (i_nrst),
    .i_load   (load_now),
    .i_init   (pre_reg[interval_timer_pkg::PRE_VALUE_HI:
                       interval_timer_pkg::PRE_VALUE_LO]), // R14
    .i_tick   (pre_tick),
    .i_hold   (1'h0),
    .i_reload (1'h1),
    .o_count  (pre_count),
    .o_end    (pre_end)
  ); // R11

  countdown_stage #(
    .W(8)
  ) u_interval_counter (
    .i_sys_clk(i_sys_clk),
    .i_nrst   (i_nrst),
    .i_load   (load_now),
    .i_init   (init_reg),
    .i_tick   (pre_end), // R7
    .i_hold   (done_reg),
    .i_reload (continuous), // R3
    .o_count  (cnt_count),
    .o_end    (eoc)
  ); // R1

  ////////////////////////////////////////////////////////////////////////////
  // Next values
  always_comb begin
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next = i_reg_wdata;
    end else if (load_now) begin
      mode_next[interval_timer_pkg::MODE_LOAD_BIT] = 1'h0; // R13
    end
    pre_next  = wr_pre ? i_reg_wdata : pre_reg; // R5
    init_next = wr_count ? i_reg_wdata : init_reg; // R5 R4

    if (!enable || load_now) begin
      div_next = 2'h0;
    end else begin
      div_next = div_reg + 2'h1; // R6
    end

    done_next = done_reg;
    if (load_now) begin
      done_next = 1'h0;
    end else if (eoc && !continuous) begin
      done_next = 1'h1; // R15
    end

    toggle_next = toggle_reg;
    if (load_now) begin
      toggle_next = 1'h1;
    end else if (eoc) begin
      toggle_next = ~toggle_reg; // R10
    end

    irq_next    = eoc; // R15
    clkout_next = ~clkout_reg;
    active_next = (out_sel == interval_timer_pkg::OUT_SEL_TOGGLE) ||
                  (out_sel == interval_timer_pkg::OUT_SEL_CLOCK);
    case (out_sel)
      interval_timer_pkg::OUT_SEL_TOGGLE: pin_next = toggle_reg; // R9
      interval_timer_pkg::OUT_SEL_CLOCK:  pin_next = clkout_reg; // R9
      default:                            pin_next = 1'h0;
    endcase

    case (i_reg_addr)
      interval_timer_pkg::ADDR_MODE:     rdata_next = mode_reg;
      interval_timer_pkg::ADDR_COUNT:    rdata_next = cnt_count;
      interval_timer_pkg::ADDR_PRESCALE: rdata_next = pre_reg;
      default:                           rdata_next = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      mode_reg   <= interval_timer_pkg::MODE_RESET; // R17
      pre_reg    <= interval_timer_pkg::PRESCALE_RESET;
      init_reg   <= interval_timer_pkg::INIT_RESET;
      div_reg    <= 2'h0;
      done_reg   <= 1'h0;
      toggle_reg <= interval_timer_pkg::TOGGLE_RESET;
      clkout_reg <= 1'h0;
      pin_reg    <= 1'h0;
      active_reg <= 1'h0; // R17
      irq_reg    <= 1'h0;
      rdata_reg  <= 8'h00;
    end else begin
      mode_reg   <= mode_next;
      pre_reg    <= pre_next;
      init_reg   <= init_next;
      div_reg    <= div_next;
      done_reg   <= done_next;
      toggle_reg <= toggle_next;
      clkout_reg <= clkout_next;
      pin_reg    <= pin_next;
      active_reg <= active_next;
      irq_reg    <= irq_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign o_reg_rdata         = rdata_reg;
  assign o_port5_bit6_pin    = pin_reg;
  assign o_timer_out_active  = active_reg;
  assign o_counter_interrupt = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  a_load_self_clear: assert property ( // R13
    load_now && !wr_mode |=> !mode_reg[interval_timer_pkg::MODE_LOAD_BIT])
    else $error("load bit did not clear itself");

  a_load_copies_init: assert property ( // R13
    load_now |=> cnt_count == $past(init_reg) &&
                 pre_count == $past(pre_reg[7:2]) && toggle_reg)
    else $error("load did not copy initial values");

  a_first_tick_four: assert property ( // R6
    $rose(enable) && !load_now && !wr_mode |->
      (!int_tick)[*3] ##1 (int_tick || !enable || load_now))
    else $error("first timer tick not four clocks after enable");

  a_tick_spacing_four: assert property ( // R7
    int_tick |=> (!int_tick)[*3])
    else $error("timer ticks closer than four clocks");

  a_single_pass_rest: assert property ( // R15
    eoc && !continuous |=> cnt_count == 8'h00 && done_reg)
    else $error("single-pass counter not resting at zero");

  a_continuous_reload: assert property ( // R3
    eoc && continuous |=> cnt_count == $past(init_reg) && !done_reg)
    else $error("continuous counter did not reload");

  a_eoc_irq_toggle: assert property ( // R10
    eoc |=> irq_reg && toggle_reg != $past(toggle_reg))
    else $error("end-of-count missed interrupt or toggle");

  a_disabled_holds: assert property ( // R2
    !enable && !load_now |=> cnt_count == $past(cnt_count))
    else $error("counter moved while disabled");

  a_pin_follows_sel: assert property ( // R9
    out_sel == interval_timer_pkg::OUT_SEL_TOGGLE && !wr_mode
      |=> o_port5_bit6_pin == $past(toggle_reg) && o_timer_out_active)
    else $error("timer output pin does not follow toggle");

  a_prescale_write: assert property ( // R5
    wr_pre |=> pre_reg == $past(i_reg_wdata))
    else $error("prescale write did not land");

  a_count_write: assert property ( // R5
    wr_count |=> init_reg == $past(i_reg_wdata))
    else $error("initial count write did not land");

  a_read_prescale: assert property ( // R12
    i_reg_addr == interval_timer_pkg::ADDR_PRESCALE
      |=> o_reg_rdata == $past(pre_reg))
    else $error("prescale read data wrong");

  a_out_off_low: assert property ( // R17
    out_sel != interval_timer_pkg::OUT_SEL_TOGGLE &&
      out_sel != interval_timer_pkg::OUT_SEL_CLOCK
      |=> !o_port5_bit6_pin && !o_timer_out_active)
    else $error("timer output not off when deselected");

  a_clock_out_flips: assert property ( // R9
    out_sel == interval_timer_pkg::OUT_SEL_CLOCK &&
      $past(out_sel) == interval_timer_pkg::OUT_SEL_CLOCK
      |=> o_port5_bit6_pin != $past(o_port5_bit6_pin))
    else $error("clock output pin not toggling");

  a_single_pass_holds: assert property ( // R15
    done_reg && !load_now |=> cnt_count == 8'h00 && !o_counter_interrupt)
    else $error("single-pass counter left its rest");

endmodule : prescaled_interval_counter
`default_nettype wire

/* pkg/interval_timer_pkg.sv */
// Purpose: Shared constants of the prescaled interval counter
// Assumes: Byte-wide register file port driven by the processor core
// Notes:   Offsets are register file addresses of the block
package interval_timer_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register file addresses
  localparam logic [7:0] ADDR_MODE     = 8'hf1;
  localparam logic [7:0] ADDR_COUNT    = 8'hf2;
  localparam logic [7:0] ADDR_PRESCALE = 8'hf3;

  //////////////////////////////////////////////////////////////////////////
  // Mode register fields
  localparam int MODE_LOAD_BIT   = 2;
  localparam int MODE_ENABLE_BIT = 3;
  localparam int MODE_OUT_LO     = 6;
  localparam int MODE_OUT_HI     = 7;

  localparam logic [1:0] OUT_SEL_TOGGLE = 2'h2;
  localparam logic [1:0] OUT_SEL_CLOCK  = 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // Prescale register fields
  localparam int PRE_CONT_BIT   = 0;
  localparam int PRE_INTCLK_BIT = 1;
  localparam int PRE_VALUE_LO   = 2;
  localparam int PRE_VALUE_HI   = 7;

  //////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] INIT_RESET     = 8'h00;
  localparam logic       TOGGLE_RESET   = 1'h1;

  //////////////////////////////////////////////////////////////////////////
  // Timer clock divider: tick on the last of four system clocks
  localparam int         TIMER_DIV_RATIO = 4;
  localparam logic [1:0] TIMER_DIV_LAST  = 2'(TIMER_DIV_RATIO - 1);

endpackage : interval_timer_pkg

/* verilog/countdown_stage.sv */
// Purpose: Reloadable down-counter stage of the divide chain
// Assumes: One tick pulse per count; value 0 stands for 2**W
// Notes:   End-of-count is flagged while the count is 1 and a tick arrives
`timescale 1ns/1ps
`default_nettype none
module countdown_stage #(
  parameter int W = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_init,
  input  wire logic         i_tick,
  input  wire logic         i_hold,
  input  wire logic         i_reload,
  output logic      [W-1:0] o_count,
  output logic              o_end
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    o_end      = i_tick & ~i_hold & (count_reg == W'(1));
    count_next = count_reg;
    if (i_load) begin
      count_next = i_init;
    end else if (i_tick && !i_hold) begin
      if (o_end) begin
        count_next = i_reload ? i_init : '0;
      end else begin
        count_next = count_reg - W'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;

endmodule : countdown_stage
`default_nettype wire

/* tb/reg_host.sv */
// Purpose: Processor core model reaching the timer's register file
// Assumes: One byte write per strobe, read data one clock after address
// Notes:   Plain register moves only, no special operations
`timescale 1ns/1ps
`default_nettype none
module reg_host (
  input  wire logic       i_sys_clk,
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic      [7:0] o_reg_wdata,
  input  wire logic [7:0] i_reg_rdata
);
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // Data is scrambled after the strobe so stale bytes are never reused
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    o_reg_wr    <= 1'b1;
    @(posedge i_sys_clk);
    o_reg_wr    <= 1'b0;
    o_reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_reg_addr <= a;
    @(posedge i_sys_clk);
    #1;
    d = i_reg_rdata;
  endtask : rd
endmodule : reg_host
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench of the prescaled interval counter
// Assumes: Core model drives the register file, bench drives the count pin
// Notes:   Intervals are measured in system clocks between interrupts
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic       i_sys_clk = 1'b0;
  logic       i_nrst    = 1'b0;
  logic       ext_pin   = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [7:0] v2;
  logic       wr;
  logic       pin;
  logic       active;
  logic       irq;
  logic       p1;
  int         n_errors = 0;
  int         checks   = 0;
  int         n;
  int         k;
  row_s       rows[5] = '{'{8'hf3, 8'ha5, 8'ha5}, '{8'hf1, 8'hc0, 8'hc0},
                          '{8'hf1, 8'h84, 8'h80}, '{8'h10, 8'h55, 8'h00},
                          '{8'hf1, 8'h40, 8'h40}};

  always #10 i_sys_clk = ~i_sys_clk;

  prescaled_interval_counter dut (
    .i_sys_clk           (i_sys_clk),
    .i_nrst              (i_nrst),
    .i_reg_addr          (addr),
    .i_reg_wr            (wr),
    .i_reg_wdata         (wdata),
    .o_reg_rdata         (rdata),
    .i_port5_bit2_pin    (ext_pin),
    .o_port5_bit6_pin    (pin),
    .o_timer_out_active  (active),
    .o_counter_interrupt (irq)
  );

  reg_host host (
    .i_sys_clk   (i_sys_clk),
    .o_reg_addr  (addr),
    .o_reg_wr    (wr),
    .o_reg_wdata (wdata),
    .i_reg_rdata (rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk_n(string what, int exp, int got);
    checks++;
    if (got != exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_n

  // Cycles until the next interrupt pulse, bounded
  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      c++;
    end while (irq !== 1'b1 && c < 2000);
    if (irq !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED interrupt expected pulse seen none");
      tally_and_finish();
    end
  endtask : wait_irq

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      host.rd(8'hf1 + 8'(i), v);
      chk8("reset reg", 8'h00, v);
    end
    chk8("reset outs", 8'h00, {5'h0, pin, active, irq});
    $display("test reset done");
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, v);
      chk8("reg readback", rows[i].e, v);
    end
    chk8("out off", 8'h00, {7'h0, active});
    host.wr(8'hf1, 8'hc0);
    repeat (3) @(posedge i_sys_clk);
    #1 p1 = pin;
    @(posedge i_sys_clk);
    #1 chk8("clock out", {6'h0, 1'b1, ~p1}, {6'h0, active, pin});
    $display("test registers done");
    host.wr(8'hf2, 8'h03);
    host.wr(8'hf3, 8'h07);
    host.wr(8'hf1, 8'h8c);
    wait_irq(n);
    wait_irq(n);
    chk_n("interval", 12, n);
    host.rd(8'hf1, v);
    chk8("load clear", 8'h88, v);
    repeat (2) @(posedge i_sys_clk);
    #1 p1 = pin;
    wait_irq(n);
    repeat (2) @(posedge i_sys_clk);
    #1 chk8("toggle", {7'h0, ~p1}, {7'h0, pin});
    host.wr(8'hf2, 8'h05);
    wait_irq(n);
    wait_irq(n);
    chk_n("new init", 20, n);
    host.wr(8'hf3, 8'h0b);
    wait_irq(n);
    wait_irq(n);
    chk_n("new prescale", 40, n);
    host.wr(8'hf1, 8'h80);
    host.rd(8'hf2, v);
    repeat (30) @(posedge i_sys_clk);
    host.rd(8'hf2, v2);
    chk8("frozen count", v, v2);
    host.wr(8'hf1, 8'h88);
    wait_irq(n);
    wait_irq(n);
    chk_n("resumed", 40, n);
    $display("test continuous done");
    host.wr(8'hf3, 8'h03);
    host.wr(8'hf2, 8'h01);
    host.wr(8'hf1, 8'h8c);
    wait_irq(n);
    wait_irq(n);
    chk_n("divide 64", 256, n);
    $display("test divide done");
    host.wr(8'hf3, 8'h06);
    host.wr(8'hf2, 8'h02);
    host.wr(8'hf1, 8'h8c);
    wait_irq(n);
    k = 0;
    repeat (40) begin
      @(posedge i_sys_clk);
      #1 k += int'(irq === 1'b1);
    end
    chk_n("single pass", 0, k);
    host.rd(8'hf2, v);
    chk8("rest count", 8'h00, v);
    $display("test single done");
    host.wr(8'hf3, 8'h05);
    host.wr(8'hf2, 8'h02);
    host.wr(8'hf1, 8'h8c);
    k = 0;
    for (int i = 0; i < 80; i++) begin
      @(posedge i_sys_clk);
      ext_pin <= (i % 8 < 4) && (i < 64);
      #1 k += int'(irq === 1'b1);
    end
    chk_n("ext count", 4, k);
    $display("test external done");
    @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    host.rd(8'hf1, v);
    chk8("mid reset mode", 8'h00, v);
    chk8("mid reset outs", 8'h00, {5'h0, pin, active, irq});
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
